// [bench/speed_agree_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module speed_agree_monitor
   import speed_agree_pkg::*;
#(
   parameter int SPEED_WIDTH = SPEED_W,
   parameter int TERMS       = NUM_TERMS
) (
   input wire logic                   i_core_clk,     // clock
   input wire logic                   i_sys_rst,      // reset
   input wire logic [SPEED_WIDTH-1:0] i_ref_speed,    // reference
   input wire logic [SPEED_WIDTH-1:0] i_det_speed,    // detected
   input wire logic [SPEED_WIDTH-1:0] i_max_speed,    // full scale
   input wire logic                   i_overload_lag, // overload
   input wire logic [7:0]             i_addr,         // address
   input wire logic [31:0]            i_wdata,        // write data
   input wire logic                   i_wr,           // write
   input wire logic                   i_rd,           // read
   input wire logic [31:0]            o_rdata,        // read data
   input wire logic                   o_speed_agree,  // agree
   input wire logic                   o_fb_error,     // error
   input wire logic                   o_coast_stop,   // coast
   input wire logic                   o_alarm1,       // alarm one
   input wire logic                   o_alarm2,       // alarm two
   input wire logic [TERMS-1:0]       o_term          // terminals
);
   cfg_s                   c_ff;
   logic [15:0]            t_ff;
   int                     run_ff;
   logic [SPEED_WIDTH-1:0] gap;
   logic                   outside;
   // shadow settings with the same clamping, so the checks follow software
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) c_ff <= '0;
      else if (i_wr && i_addr == 8'h00) c_ff <= {(i_wdata[9:0] > HYST_MAX) ? HYST_MAX : i_wdata[9:0],
         (i_wdata[19:10] > TIME_MAX) ? TIME_MAX : i_wdata[19:10],
         i_wdata[21] & ~i_wdata[20], i_wdata[20] & ~i_wdata[21]};
   end
   // terminal codes, low two terminals only
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) t_ff <= '0;
      else if (i_wr && i_addr == 8'h04) t_ff <= i_wdata[15:0];
   end
   // consecutive cycles out of band, for the minimum hold time
   always_ff @(posedge i_core_clk) begin
      run_ff <= (i_sys_rst || !outside) ? 0 : run_ff + 1;
   end
   // lag below reference is excused unless the strict policy is chosen
   always_comb begin
      gap = (i_ref_speed > i_det_speed) ? i_ref_speed - i_det_speed : i_det_speed - i_ref_speed;
      outside = (i_max_speed != '0) &&
         (int'(gap) * PERMILLE_FULL / int'(i_max_speed) > int'(c_ff.hysteresis_width_setting))
         && !(i_det_speed < i_ref_speed && i_overload_lag && c_ff.feedback_error_policy != POL_STOP_ALARM2);
   end
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_sys_rst);
   property p_agree_set; !outside |-> ##2 o_speed_agree; endproperty
   a_agree_set: assert property (p_agree_set) else $error("agree flag missing in band");
   property p_drop_now;
      c_ff.detection_time_setting == 10'h0 && outside |-> ##2 (!o_speed_agree && o_fb_error);
   endproperty
   a_drop_now: assert property (p_drop_now) else $error("no drop with zero timer");
   property p_hold; $fell(o_speed_agree) |-> run_ff >= (int'(c_ff.detection_time_setting) - 1) * TICK_CYCLES; endproperty
   a_hold: assert property (p_hold) else $error("agree flag dropped early");
   property p_trip; $rose(o_coast_stop) |-> o_fb_error && (o_alarm1 ^ o_alarm2); endproperty
   a_trip: assert property (p_trip) else $error("coast without error and alarm");
   property p_alarm1; $rose(o_alarm1) |-> c_ff.feedback_error_policy == POL_STOP_ALARM1; endproperty
   a_alarm1: assert property (p_alarm1) else $error("alarm one under wrong policy");
   property p_alarm2; $rose(o_alarm2) |-> c_ff.feedback_error_policy == POL_STOP_ALARM2; endproperty
   a_alarm2: assert property (p_alarm2) else $error("alarm two under wrong policy");
   property p_run0; $rose(o_fb_error) && c_ff.feedback_error_policy == POL_CONTINUE |-> (!o_coast_stop)[*3]; endproperty
   a_run0: assert property (p_run0) else $error("continue policy stopped");
   property p_term_ag; $past(t_ff[6:0]) == TERM_SPEED_AGREE |-> o_term[0] == $past(o_speed_agree); endproperty
   a_term_ag: assert property (p_term_ag) else $error("terminal not showing agree");
   property p_term_er; $past(t_ff[14:8]) == TERM_FB_ERROR |-> o_term[1] == $past(o_fb_error); endproperty
   a_term_er: assert property (p_term_er) else $error("terminal not showing error");
   property p_rd_idle; !i_rd |=> o_rdata == 32'h0; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");
   c_alarm1: cover property (o_alarm1);
   c_alarm2: cover property (o_alarm2);
   c_drop: cover property ($fell(o_speed_agree));
endmodule
bind speed_agreement_feedback_error speed_agree_monitor #(.SPEED_WIDTH(SPEED_WIDTH), .TERMS(TERMS)) u_mon (.*);
`default_nettype wire

// [bench/speed_agreement_feedback_error_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module speed_agreement_feedback_error_bench;
   import speed_agree_pkg::*;
   logic        i_core_clk, i_sys_rst, i_overload_lag, i_fault_clear, i_wr, i_rd, slow;
   logic        rd_seen = 1'b0;
   logic [7:0]  i_addr;
   logic [31:0] i_wdata, o_rdata;
   logic [15:0] ref_cmd, slip, ref_speed, det_speed;
   logic [31:0] exp_q[$];
   int          errors, n_tests;
   int          cyc = 0;
   speed_loop_model loop_m (.i_core_clk(i_core_clk), .i_ref_cmd(ref_cmd), .i_slip(slip), .i_slow(slow),
      .o_ref_speed(ref_speed), .o_det_speed(det_speed));
   speed_agreement_feedback_error #(.TERMS(4)) dut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_ce(1'b1),
      .i_ref_speed(ref_speed), .i_det_speed(det_speed), .i_max_speed(16'h03e8), .i_overload_lag(i_overload_lag),
      .i_fault_clear(i_fault_clear), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .o_speed_agree(), .o_fb_error(), .o_coast_stop(), .o_alarm1(), .o_alarm2(), .o_term());
   // 25 MHz core clock
   initial begin
      i_core_clk = 1'b0;
      forever #20 i_core_clk = ~i_core_clk;
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // one comparison of read data against its note
   task automatic check_rdata(input logic [31:0] e, input logic [31:0] s);
      n_tests++;
      if (s !== e) begin
         errors++;
         $display("CHECK FAILED rdata expected %h seen %h", e, s);
      end
   endtask
   // read answers are matched against the oldest note; a hang is cut off
   always @(posedge i_core_clk) begin
      rd_seen <= i_rd;
      cyc <= cyc + 1;
      if (rd_seen) begin
         check_rdata(exp_q[0], o_rdata);
         void'(exp_q.pop_front());
      end
      if (cyc == 5000) begin
         errors++;
         finish_test();
      end
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_core_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_core_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge i_core_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      exp_q.push_back(e);
      @(posedge i_core_clk);
      i_rd <= 1'b0;
   endtask
   // random reference, exact slip so band edges are hit precisely
   task automatic speed(input logic [15:0] s, input logic sl);
      @(posedge i_core_clk);
      ref_cmd <= 16'(200 + $urandom_range(500));
      slip <= s;
      slow <= sl;
      i_overload_lag <= sl;
      repeat (4) @(posedge i_core_clk);
   endtask
   task automatic clear();
      @(posedge i_core_clk);
      i_fault_clear <= 1'b1;
      @(posedge i_core_clk);
      i_fault_clear <= 1'b0;
   endtask
   function automatic logic [31:0] stat(input logic a, e, c, x1, x2);
      return {27'h0, a, e, c, x1, x2};
   endfunction
   initial begin
      i_sys_rst = 1'b1;
      {i_wr, i_rd, i_fault_clear, i_overload_lag, slow} = '0;
      {i_addr, i_wdata, ref_cmd, slip} = '0;
      {errors, n_tests} = '0;
      void'($urandom(32'h1dbb4b96));
      repeat (6) @(posedge i_core_clk);
      i_sys_rst <= 1'b0;
      wr(8'h00, 32'hffffffff);
      rd(8'h00, {12'h0, TIME_MAX, HYST_MAX});
      rd(8'h10, 32'h0);
      wr(8'h04, {17'h0, TERM_FB_ERROR, 1'b0, TERM_SPEED_AGREE});
      rd(8'h04, {17'h0, TERM_FB_ERROR, 1'b0, TERM_SPEED_AGREE});
      $display("test settings done");
      for (int p = 0; p < 3; p++) begin
         wr(8'h00, {10'h0, 2'(p), 10'h0, 10'h032});
         speed(16'h0032, 1'b0);
         rd(8'h08, stat(1'b1, 1'b0, 1'b0, 1'b0, 1'b0));
         speed(16'h0033, 1'b0);
         rd(8'h08, stat(1'b0, 1'b1, p != 0, p == 1, p == 2));
         speed(16'h0032, 1'b0);
         rd(8'h08, stat(1'b1, p != 0, p != 0, p == 1, p == 2));
         clear();
         speed(16'h0064, 1'b1);
         rd(8'h08, stat(p != 2, p == 2, p == 2, 1'b0, p == 2));
         speed(16'h0000, 1'b0);
         clear();
         rd(8'h08, stat(1'b1, 1'b0, 1'b0, 1'b0, 1'b0));
         $display("test policy %0d done", p);
      end
      wr(8'h00, {12'h0, 10'h002, 10'h032});
      speed(16'h0064, 1'b0);
      rd(8'h0c, 32'h64);
      repeat (1000) @(posedge i_core_clk);
      rd(8'h08, stat(1'b1, 1'b0, 1'b0, 1'b0, 1'b0));
      $display("test hold done");
      wr(8'h00, 32'h0);
      speed(16'h0001, 1'b0);
      rd(8'h08, stat(1'b0, 1'b1, 1'b0, 1'b0, 1'b0));
      speed(16'h0000, 1'b0);
      rd(8'h08, stat(1'b1, 1'b0, 1'b0, 1'b0, 1'b0));
      $display("test zero width done");
      repeat (3) @(posedge i_core_clk);
      finish_test();
   end
endmodule
`default_nettype wire

// [bench/speed_loop_model.sv]
`timescale 1ns/1ps
`default_nettype none
// regulator reference and encoder feedback with a commanded slip
module speed_loop_model (
   input  wire logic        i_core_clk,  // core clock
   input  wire logic [15:0] i_ref_cmd,   // reference target
   input  wire logic [15:0] i_slip,      // encoder offset from reference
   input  wire logic        i_slow,      // encoder lags, drive held back
   output logic [15:0]      o_ref_speed, // reference speed
   output logic [15:0]      o_det_speed  // detected speed
);
   // speeds move just after the edge, like a sampled speed loop
   always_ff @(posedge i_core_clk) begin
      o_ref_speed <= i_ref_cmd;
      o_det_speed <= i_slow ? i_ref_cmd - i_slip : i_ref_cmd + i_slip;
   end
endmodule
`default_nettype wire

// [inc/speed_agree_pkg.sv]
package speed_agree_pkg;
   // setting widths and limits
   localparam int          SPEED_W          = 16;            // reference / detected speed width
   localparam int          HYST_W           = 10;            // width setting in 0.1 % steps
   localparam int          TIME_W           = 10;            // time setting in 0.01 s steps
   localparam logic [9:0]  HYST_MAX         = 10'h1f4;       // 50.0 %
   localparam logic [9:0]  TIME_MAX         = 10'h3e8;       // 10.00 s
   localparam int          PERMILLE_FULL    = 1000;          // 100.0 % in 0.1 % steps
   // timing
   localparam int          CLK_HZ           = 25000000;
   localparam int          TICK_MS          = 10;            // time setting step, 0.01 s
   localparam int          TICK_CYCLES      = CLK_HZ / 1000 * TICK_MS;
   // policy codes
   localparam logic [1:0]  POL_CONTINUE     = 2'h0;
   localparam logic [1:0]  POL_STOP_ALARM1  = 2'h1;
   localparam logic [1:0]  POL_STOP_ALARM2  = 2'h2;
   // terminal function codes
   localparam logic [6:0]  TERM_SPEED_AGREE = 7'h47;         // 71
   localparam logic [6:0]  TERM_FB_ERROR    = 7'h4c;         // 76
   localparam int          NUM_TERMS        = 4;             // four code bytes fit the 32-bit assign register
   typedef struct packed {
      logic [HYST_W-1:0] hysteresis_width_setting;
      logic [TIME_W-1:0] detection_time_setting;
      logic [1:0]        feedback_error_policy;
   } cfg_s;
   typedef struct packed {
      logic speed_agree_flag;
      logic feedback_error_flag;
      logic coast_stop;
      logic alarm1;
      logic alarm2;
   } status_s;
endpackage

// [rtl/speed_agreement_feedback_error.sv]
// Overview of operation
// - agreement flag is high while the deviation lies inside the hysteresis width.
// - flag clears only after deviation stays outside for at least the detection time less one 0.01 s step.
// - hysteresis width accepts 0.0 to 50.0 percent of maximum speed.
// - detection time accepts 0.00 to 10.00 seconds in 0.01 second steps.
// - feedback error declared when deviation stays outside for the detection time.
// - policy 0 continue, 1 stop with alarm one, 2 stop with alarm two.
// - policy 0 raises the error flag and keeps the motor running.
// - policy 1 or 2 coasts to stop, raises alarm and error flag.
// - policy 0 or 1 ignores overload lag below reference.
// - policy 2 counts overload lag below reference as an error too.
// - agreement flag routed to an output terminal assigned code 71.
// - error flag routed to an output terminal assigned code 76.
`timescale 1ns/1ps
`default_nettype none
module speed_agreement_feedback_error
   import speed_agree_pkg::*;
#(
   parameter int SPEED_WIDTH = SPEED_W,
   parameter int TERMS       = NUM_TERMS
) (
   input  wire logic                   i_core_clk,       // core clock, 25 MHz
   input  wire logic                   i_sys_rst,        // sync reset, active high
   input  wire logic                   i_ce,             // clock enable, freezes state when low
   input  wire logic [SPEED_WIDTH-1:0] i_ref_speed,      // reference speed from regulator
   input  wire logic [SPEED_WIDTH-1:0] i_det_speed,      // detected speed from encoder path
   input  wire logic [SPEED_WIDTH-1:0] i_max_speed,      // speed that stands for 100 %
   input  wire logic                   i_overload_lag,   // drive cannot follow under overload
   input  wire logic                   i_fault_clear,    // alarm reset pulse
   input  wire logic [7:0]             i_addr,           // register address
   input  wire logic [31:0]            i_wdata,          // register write data
   input  wire logic                   i_wr,             // write strobe
   input  wire logic                   i_rd,             // read strobe
   output logic [31:0]                 o_rdata,          // read data, one cycle after strobe
   output logic                        o_speed_agree,    // speed agreement flag
   output logic                        o_fb_error,       // feedback error flag
   output logic                        o_coast_stop,     // coast-to-stop request
   output logic                        o_alarm1,         // alarm, variant one
   output logic                        o_alarm2,         // alarm, variant two
   output logic [TERMS-1:0]            o_term            // general output terminals
);
   // register map
   //   0x00 settings: [9:0] band width in 0.1 %, [19:10] time in 0.01 s, [21:20] error policy
   //   0x04 terminal codes: byte g holds the function code of terminal g, low seven bits used
   //   0x08 status: bit 4 agree, bit 3 error, bit 2 coast, bit 1 alarm one, bit 0 alarm two
   //   0x0c deviation in 0.1 % of maximum speed, saturating
   // unmapped addresses read zero and ignore writes
   localparam logic [7:0] REG_CFG    = 8'h00;
   localparam logic [7:0] REG_TERM   = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_DEV    = 8'h0c;
   localparam int         CFG_TIME_LSB = 10;
   localparam int         CFG_POL_LSB  = 20;
   localparam int         TA_W         = 7;

   // parameter limits, refused while elaborating
   if (SPEED_WIDTH < 4 || SPEED_WIDTH > 24) begin : g_bad_speed
      $error("speed width out of range");
   end
   if (TERMS < 1 || TERMS > 4) begin : g_bad_terms
      $error("at most four terminals fit the assign register");
   end

   // clamp a setting to its legal maximum
   function automatic logic [9:0] clamp10(input logic [9:0] v, input logic [9:0] lim);
      clamp10 = (v > lim) ? lim : v;
   endfunction

   // a terminal shows a flag when its assigned code matches
   function automatic logic term_sel(input logic [TA_W-1:0] code, input logic agree, input logic err);
      term_sel = (code == TERM_SPEED_AGREE) ? agree : ((code == TERM_FB_ERROR) ? err : 1'b0);
   endfunction

   cfg_s                  cfg_ff;
   logic [TERMS*8-1:0]    term_assign_ff;
   status_s               stat_ff;
   logic [TIME_W-1:0]     out_cnt_ff;
   logic [HYST_W+1:0]     dev_pct_ff;
   logic                  outside_ff;
   logic [31:0]           rdata_ff;
   logic                  tick;
   logic                  timeout;
   logic                  err_cond;

   tick_gen #(
      .CYCLES (TICK_CYCLES)
   ) u_tick (
      .i_core_clk (i_core_clk),
      .i_sys_rst  (i_sys_rst),
      .i_ce       (i_ce),
      .o_tick     (tick)
   );

   // configuration writes, settings clamped to their accepted ranges
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         cfg_ff         <= '0;
         term_assign_ff <= '0;
      end else if (i_ce && i_wr) begin
         if (i_addr == REG_CFG) begin
            cfg_ff.hysteresis_width_setting <= clamp10(i_wdata[HYST_W-1:0], HYST_MAX);
            cfg_ff.detection_time_setting   <= clamp10(i_wdata[CFG_TIME_LSB +: TIME_W], TIME_MAX);
            // unused code 3 falls back to continue so a bad write never trips
            cfg_ff.feedback_error_policy    <= (i_wdata[CFG_POL_LSB +: 2] > POL_STOP_ALARM2) ?
                                               POL_CONTINUE : i_wdata[CFG_POL_LSB +: 2];
         end
         if (i_addr == REG_TERM) begin
            term_assign_ff <= i_wdata[TERMS*8-1:0];
         end
      end
   end

   // deviation in 0.1 % of maximum speed, recomputed every cycle; one pipeline stage
   // keeps the divider off the flag path
   logic [SPEED_WIDTH-1:0] abs_diff;
   logic [SPEED_WIDTH+9:0] scaled;
   logic                   lagging;
   always_comb begin
      abs_diff = (i_ref_speed >= i_det_speed) ? i_ref_speed - i_det_speed : i_det_speed - i_ref_speed;
      scaled   = (i_max_speed == '0) ? '0 :
                 (SPEED_WIDTH+10)'(({10'h0, abs_diff} * (SPEED_WIDTH+10)'(PERMILLE_FULL)) /
                                   {10'h0, i_max_speed});
      lagging  = i_det_speed < i_ref_speed;
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         dev_pct_ff <= '0;
         outside_ff <= 1'b0;
      end else if (i_ce) begin
         dev_pct_ff <= (scaled > (SPEED_WIDTH+10)'(2*PERMILLE_FULL)) ? '1 : scaled[HYST_W+1:0];
         // overload lag is excused unless policy 2 asks for it
         outside_ff <= (scaled > (SPEED_WIDTH+10)'(cfg_ff.hysteresis_width_setting)) &&
                       !(lagging && i_overload_lag &&
                         cfg_ff.feedback_error_policy != POL_STOP_ALARM2);
      end
   end

   // outside-band timer in 0.01 s steps; any return inside the band restarts it
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         out_cnt_ff <= '0;
      end else if (i_ce) begin
         if (!outside_ff) begin
            out_cnt_ff <= '0;
         end else if (tick && !timeout) begin
            out_cnt_ff <= out_cnt_ff + 1'b1;
         end
      end
   end

   // a zero time setting means outside the band drops the flag at once
   assign timeout  = outside_ff && (out_cnt_ff >= cfg_ff.detection_time_setting);
   assign err_cond = timeout;

   // agreement flag and error reaction
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         stat_ff <= '0;
      end else if (i_ce) begin
         if (!outside_ff) begin
            stat_ff.speed_agree_flag <= 1'b1;
         end else if (timeout) begin
            stat_ff.speed_agree_flag <= 1'b0;
         end
         // error flag follows the condition for policy 0; a trip latches until cleared
         if (err_cond) begin
            stat_ff.feedback_error_flag <= 1'b1;
         end else if (!stat_ff.coast_stop || i_fault_clear) begin
            // a clear only wins when no new detection arrives in the same cycle
            stat_ff.feedback_error_flag <= 1'b0;
         end
         // set wins over a clear arriving in the same cycle
         if (err_cond && cfg_ff.feedback_error_policy != POL_CONTINUE) begin
            stat_ff.coast_stop <= 1'b1;
            stat_ff.alarm1     <= stat_ff.alarm1 | (cfg_ff.feedback_error_policy == POL_STOP_ALARM1);
            stat_ff.alarm2     <= stat_ff.alarm2 | (cfg_ff.feedback_error_policy == POL_STOP_ALARM2);
         end else if (i_fault_clear) begin
            stat_ff.coast_stop          <= 1'b0;
            stat_ff.alarm1              <= 1'b0;
            stat_ff.alarm2              <= 1'b0;
         end
      end
   end

   // register reads, data valid the cycle after the strobe
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         rdata_ff <= '0;
      end else if (i_ce) begin
         rdata_ff <= '0;
         if (i_rd) begin
            unique case (i_addr)
               REG_CFG:    rdata_ff <= 32'({cfg_ff.feedback_error_policy, cfg_ff.detection_time_setting,
                                            cfg_ff.hysteresis_width_setting});
               REG_TERM:   rdata_ff <= 32'(term_assign_ff);
               REG_STATUS: rdata_ff <= 32'(stat_ff);
               REG_DEV:    rdata_ff <= 32'(dev_pct_ff);
               default:    rdata_ff <= '0;
            endcase
         end
      end
   end

   // terminal routing
   logic [TERMS-1:0] term_nxt;
   for (genvar g = 0; g < TERMS; g++) begin : g_term
      assign term_nxt[g] = term_sel(term_assign_ff[g*8 +: TA_W], stat_ff.speed_agree_flag,
                                    stat_ff.feedback_error_flag);
   end

   logic [TERMS-1:0] term_ff;
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         term_ff <= '0;
      end else if (i_ce) begin
         term_ff <= term_nxt;
      end
   end

   assign o_rdata       = rdata_ff;
   assign o_speed_agree = stat_ff.speed_agree_flag;
   assign o_fb_error    = stat_ff.feedback_error_flag;
   assign o_coast_stop  = stat_ff.coast_stop;
   assign o_alarm1      = stat_ff.alarm1;
   assign o_alarm2      = stat_ff.alarm2;
   assign o_term        = term_ff;
endmodule
`default_nettype wire

// [rtl/tick_gen.sv]
`timescale 1ns/1ps
`default_nettype none
// divides the core clock into the 0.01 s timer step
module tick_gen #(
   parameter int CYCLES = 250000
) (
   input  wire logic i_core_clk,  // core clock
   input  wire logic i_sys_rst,   // sync reset
   input  wire logic i_ce,        // clock enable
   output logic      o_tick       // one-cycle step pulse
);
   localparam int CW = $clog2(CYCLES);
   logic [CW-1:0] cnt_ff;

   // a divider below two would never leave its terminal count
   if (CYCLES < 2) begin : g_bad_cycles
      $error("tick_gen: CYCLES must be at least 2");
   end

   // free-running step counter
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         cnt_ff <= '0;
         o_tick <= 1'b0;
      end else if (i_ce) begin
         o_tick <= (cnt_ff == CW'(CYCLES - 1));
         cnt_ff <= (cnt_ff == CW'(CYCLES - 1)) ? '0 : cnt_ff + 1'b1;
      end
   end
endmodule
`default_nettype wire
